// ### verilog/syc_pkg.sv
package syc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PWR1 = 8'h00;
  localparam logic [7:0] OFS_PWR2 = 8'h04;
  localparam logic [7:0] OFS_WAKE = 8'h08;
  localparam logic [7:0] OFS_CLKO = 8'h0C;
  localparam logic [7:0] OFS_RSRC = 8'h10;
  // power_mgmt_ctrl_1 fields
  localparam int P1_EN = 0;
  localparam int P1_SE = 1;
  localparam int P1_RE = 2;
  localparam int P1_IE = 3;
  localparam int P1_ACK = 4;
  localparam int P1_FLAG = 7;
  // power_mgmt_ctrl_2 fields
  localparam int P2_BOV = 0;
  localparam int P2_WV = 1;
  localparam int P2_WACK = 2;
  localparam int P2_WARN = 7;
  // wakeup_timer_ctrl fields
  localparam int WK_PS_LSB = 0;
  localparam int WK_PS_W = 3;
  localparam int WK_IE = 4;
  localparam int WK_CS = 5;
  localparam int WK_ACK = 6;
  localparam int WK_FLAG = 7;
  // clock output control fields
  localparam int CO_EN = 0;
  localparam int CO_DS_LSB = 1;
  localparam int CO_DS_W = 3;
  // reset_source_register fields
  localparam int RS_BO = 1;
  localparam int RS_POR = 7;
  // reset values
  localparam logic RST_BO_EN = 1'b1;
  localparam logic RST_BO_RE = 1'b1;
  // vector numbers, lower wins
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_BROWNOUT = 5'h03;
  localparam logic [4:0] VEC_WAKEUP = 5'h19;
  // wake-up period: base tick count shifted by (select - 1)
  localparam int WK_CNT_W = 12;
  localparam logic [WK_CNT_W-1:0] WK_BASE = 12'h008;
endpackage

// ### verilog/syc_sys_ctrl.sv
// Overview of operation
// - detector runs only while enabled; select bit picks high or low trip level
// - detector switched off in any stop mode unless stop-enable is set
// - enable plus stop-enable together block the deepest stop mode
// - power-on reset sets both power-on and brownout flags in reset source
// - reset-enable makes a trip reset the system until supply recovers
// - brownout flag in reset source set after detector reset and power-on
// - enabled, irq-enabled, reset-disabled detector trip sets flag and interrupt
// - warning flag shows supply nearing trip level and never interrupts
// - separate select bit picks high or low warning level
// - wake-up timer clocked by internal 1 kHz or external clock, bit selects
// - internal slow clock is independent and feeds only the wake-up timer
// - both sources run in run, wait, light stop; external needs osc settings
// - only the internal clock runs the timer in deep stop
// - timer register: read-only flag, write-only ack, 3-bit period field
// - local enable masks the wake-up interrupt request
// - all-zero period field disables the timer and its interrupts
// - clock-out enable drives bus clock divided by divider select
// - clock-out enable forces the shared pin to output
// - all-zero divider select drives the pin constantly low
// - pin slew and drive come from the pin's own control bits
// - set flag with local enable forwards an interrupt request
// - pending sources prioritised, lower vector number wins
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module syc_sys_ctrl #(
  parameter int CLKO_DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparators and power-on
  input wire logic por_in,
  input wire logic brownout_trip,
  input wire logic warning_trip,
  // operating mode from the core
  input wire logic stop_active,
  input wire logic deep_stop_request,
  // wake-up timer clock ticks and oscillator settings
  input wire logic lfo_clk_in,
  input wire logic ext_clk_in,
  input wire logic osc_stop_enable,
  input wire logic osc_range_select,
  // shared port pin controls
  input wire logic port_data,
  input wire logic port_dir_out,
  input wire logic shared_pin_slew_enable,
  input wire logic shared_pin_drive_strength,
  // comparator controls
  output logic brownout_detector_on,
  output logic brownout_threshold_high,
  output logic warning_threshold_high,
  output logic deep_stop_allowed,
  // reset and interrupt requests
  output logic system_reset_req,
  output logic irq_brownout,
  output logic irq_wakeup,
  output logic irq_pending,
  output logic [4:0] irq_vector,
  // shared port pin
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe_n,
  output logic shared_port_pin_slew,
  output logic shared_port_pin_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // control state
  logic brownout_enable_r, brownout_stop_enable_r;
  logic brownout_reset_enable_r, brownout_irq_enable_r;
  logic brownout_flag_r, brownout_threshold_select_r;
  logic warning_threshold_select_r, supply_warning_r;
  logic [2:0] wakeup_period_select_r;
  logic wakeup_irq_enable_r, wakeup_clock_select_r, wakeup_flag_r;
  logic clock_out_pin_enable_r;
  logic [2:0] clock_out_divider_select_r;
  logic rsrc_por_r, rsrc_bo_r;
  logic bo_reset_r, rst_d_r;
  logic lfo_d_r, ext_d_r;
  localparam int WK_CNT_W_L = syc_pkg::WK_CNT_W;
  logic [WK_CNT_W_L-1:0] wk_cnt_r;
  logic [CLKO_DIV_W-1:0] co_cnt_r;
  logic co_lvl_r;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [WK_CNT_W_L-1:0] wake_period(input logic [2:0] sel);
    wake_period = syc_pkg::WK_BASE << (sel - 3'h1);
  endfunction

  function automatic logic [CLKO_DIV_W-1:0] clko_half(input logic [2:0] sel);
    clko_half = CLKO_DIV_W'(1) << (sel - 3'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr_en, rd_setup;
  logic [7:0] wb;
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_setup = psel & ~penable & ~pready;
  assign wb = pwdata[7:0];

  logic hit;
  always_comb begin
    hit = 1'b0;
    unique case (paddr)
      syc_pkg::OFS_PWR1, syc_pkg::OFS_PWR2, syc_pkg::OFS_WAKE,
      syc_pkg::OFS_CLKO, syc_pkg::OFS_RSRC: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (paddr)
      syc_pkg::OFS_PWR1: begin
        rd_mux[syc_pkg::P1_EN] = brownout_enable_r;
        rd_mux[syc_pkg::P1_SE] = brownout_stop_enable_r;
        rd_mux[syc_pkg::P1_RE] = brownout_reset_enable_r;
        rd_mux[syc_pkg::P1_IE] = brownout_irq_enable_r;
        rd_mux[syc_pkg::P1_FLAG] = brownout_flag_r;
      end
      syc_pkg::OFS_PWR2: begin
        rd_mux[syc_pkg::P2_BOV] = brownout_threshold_select_r;
        rd_mux[syc_pkg::P2_WV] = warning_threshold_select_r;
        rd_mux[syc_pkg::P2_WARN] = supply_warning_r;
      end
      syc_pkg::OFS_WAKE: begin
        // ack reads as zero
        rd_mux[syc_pkg::WK_PS_LSB +: syc_pkg::WK_PS_W] = wakeup_period_select_r;
        rd_mux[syc_pkg::WK_IE] = wakeup_irq_enable_r;
        rd_mux[syc_pkg::WK_CS] = wakeup_clock_select_r;
        rd_mux[syc_pkg::WK_FLAG] = wakeup_flag_r;
      end
      syc_pkg::OFS_CLKO: begin
        rd_mux[syc_pkg::CO_EN] = clock_out_pin_enable_r;
        rd_mux[syc_pkg::CO_DS_LSB +: syc_pkg::CO_DS_W] = clock_out_divider_select_r;
      end
      syc_pkg::OFS_RSRC: begin
        rd_mux[syc_pkg::RS_POR] = rsrc_por_r;
        rd_mux[syc_pkg::RS_BO] = rsrc_bo_r;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // no wait state: ready registered in the setup phase, high in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~hit;
      if (rd_setup) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  logic wr_p1, wr_p2, wr_wk, wr_co;
  assign wr_p1 = wr_en & (paddr == syc_pkg::OFS_PWR1);
  assign wr_p2 = wr_en & (paddr == syc_pkg::OFS_PWR2);
  assign wr_wk = wr_en & (paddr == syc_pkg::OFS_WAKE);
  assign wr_co = wr_en & (paddr == syc_pkg::OFS_CLKO);

  ////////////////////////////////////////////////////////////////////////////
  // brownout detector control
  logic det_active, trip_seen, warn_seen;
  // off in stop unless stop-enabled
  assign det_active = brownout_enable_r & (~stop_active | brownout_stop_enable_r);
  assign trip_seen = det_active & brownout_trip;
  assign warn_seen = det_active & warning_trip;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brownout_enable_r <= syc_pkg::RST_BO_EN;
      brownout_stop_enable_r <= 1'b0;
      brownout_reset_enable_r <= syc_pkg::RST_BO_RE;
      brownout_irq_enable_r <= 1'b0;
      brownout_threshold_select_r <= 1'b0;
      warning_threshold_select_r <= 1'b0;
    end else begin
      if (wr_p1) begin
        brownout_enable_r <= wb[syc_pkg::P1_EN];
        brownout_stop_enable_r <= wb[syc_pkg::P1_SE];
        brownout_reset_enable_r <= wb[syc_pkg::P1_RE];
        brownout_irq_enable_r <= wb[syc_pkg::P1_IE];
      end
      if (wr_p2) begin
        brownout_threshold_select_r <= wb[syc_pkg::P2_BOV];
        warning_threshold_select_r <= wb[syc_pkg::P2_WV];
      end
    end
  end

  // flags: a new event wins over a same-cycle acknowledge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brownout_flag_r <= 1'b0;
      supply_warning_r <= 1'b0;
    end else begin
      if (trip_seen & brownout_irq_enable_r & ~brownout_reset_enable_r) begin
        brownout_flag_r <= 1'b1;
      end else if (wr_p1 & wb[syc_pkg::P1_ACK]) begin
        brownout_flag_r <= 1'b0;
      end
      if (warn_seen) begin
        supply_warning_r <= 1'b1;
      end else if (wr_p2 & wb[syc_pkg::P2_WACK]) begin
        supply_warning_r <= 1'b0;
      end
    end
  end

  // reset held until the comparator reports the supply back above threshold
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // the request outlives the system reset it causes
      bo_reset_r <= bo_reset_r & brownout_trip;
    end else begin
      bo_reset_r <= (bo_reset_r | (trip_seen & brownout_reset_enable_r))
                    & brownout_trip;
    end
  end

  // reset source capture at reset time
  always_ff @(posedge ref_clk) begin
    rst_d_r <= rst;
    if (rst) begin
      if (por_in) begin
        rsrc_por_r <= 1'b1;
        rsrc_bo_r <= 1'b1;
      end else begin
        rsrc_por_r <= 1'b0;
        rsrc_bo_r <= bo_reset_r | (rst_d_r & rsrc_bo_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic wake-up timer
  logic lfo_rise, ext_rise, src_ok, tick, wk_on;
  assign lfo_rise = lfo_clk_in & ~lfo_d_r;
  assign ext_rise = ext_clk_in & ~ext_d_r;
  // deep stop: internal only; light stop: external needs osc kept running, low range
  always_comb begin
    src_ok = 1'b1;
    if (stop_active & deep_stop_request) begin
      src_ok = ~wakeup_clock_select_r;
    end else if (stop_active) begin
      src_ok = ~wakeup_clock_select_r
               | (osc_stop_enable & ~osc_range_select);
    end
  end
  assign tick = src_ok & (wakeup_clock_select_r ? ext_rise : lfo_rise);
  assign wk_on = wakeup_period_select_r != 3'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfo_d_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      lfo_d_r <= lfo_clk_in;
      ext_d_r <= ext_clk_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wakeup_period_select_r <= 3'h0;
      wakeup_irq_enable_r <= 1'b0;
      wakeup_clock_select_r <= 1'b0;
    end else if (wr_wk) begin
      wakeup_period_select_r <= wb[syc_pkg::WK_PS_LSB +: syc_pkg::WK_PS_W];
      wakeup_irq_enable_r <= wb[syc_pkg::WK_IE];
      wakeup_clock_select_r <= wb[syc_pkg::WK_CS];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wk_cnt_r <= '0;
      wakeup_flag_r <= 1'b0;
    end else begin
      if (~wk_on | wr_wk) begin
        wk_cnt_r <= '0;
      end else if (tick) begin
        if (wk_cnt_r >= wake_period(wakeup_period_select_r) - 1'b1) begin
          wk_cnt_r <= '0;
        end else begin
          wk_cnt_r <= wk_cnt_r + 1'b1;
        end
      end
      if (wk_on & tick & (wk_cnt_r >= wake_period(wakeup_period_select_r) - 1'b1)) begin
        wakeup_flag_r <= 1'b1;
      end else if (wr_wk & wb[syc_pkg::WK_ACK]) begin
        wakeup_flag_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clock_out_pin_enable_r <= 1'b0;
      clock_out_divider_select_r <= 3'h0;
    end else if (wr_co) begin
      clock_out_pin_enable_r <= wb[syc_pkg::CO_EN];
      clock_out_divider_select_r <= wb[syc_pkg::CO_DS_LSB +: syc_pkg::CO_DS_W];
    end
  end

  // bus clock divided by 2^select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      co_cnt_r <= '0;
      co_lvl_r <= 1'b0;
    end else if (~clock_out_pin_enable_r | (clock_out_divider_select_r == 3'h0)) begin
      co_cnt_r <= '0;
      co_lvl_r <= 1'b0;
    end else if (co_cnt_r >= clko_half(clock_out_divider_select_r) - 1'b1) begin
      co_cnt_r <= '0;
      co_lvl_r <= ~co_lvl_r;
    end else begin
      co_cnt_r <= co_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shared_port_pin_out <= 1'b0;
      shared_port_pin_oe_n <= 1'b1;
      shared_port_pin_slew <= 1'b0;
      shared_port_pin_drive <= 1'b0;
    end else begin
      shared_port_pin_out <= clock_out_pin_enable_r ? co_lvl_r : port_data;
      shared_port_pin_oe_n <= ~(clock_out_pin_enable_r | port_dir_out);
      shared_port_pin_slew <= shared_pin_slew_enable;
      shared_port_pin_drive <= shared_pin_drive_strength;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator controls, reset and interrupt requests
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brownout_detector_on <= 1'b0;
      brownout_threshold_high <= 1'b0;
      warning_threshold_high <= 1'b0;
      deep_stop_allowed <= 1'b0;
      system_reset_req <= 1'b0;
      irq_brownout <= 1'b0;
      irq_wakeup <= 1'b0;
      irq_pending <= 1'b0;
      irq_vector <= syc_pkg::VEC_RESET;
    end else begin
      brownout_detector_on <= det_active;
      brownout_threshold_high <= brownout_threshold_select_r;
      warning_threshold_high <= warning_threshold_select_r;
      deep_stop_allowed <= ~(brownout_enable_r & brownout_stop_enable_r);
      system_reset_req <= bo_reset_r;
      irq_brownout <= brownout_flag_r & brownout_irq_enable_r;
      irq_wakeup <= wakeup_flag_r & wakeup_irq_enable_r & wk_on;
      irq_pending <= bo_reset_r | (brownout_flag_r & brownout_irq_enable_r)
                     | (wakeup_flag_r & wakeup_irq_enable_r & wk_on);
      if (bo_reset_r) begin
        irq_vector <= syc_pkg::VEC_RESET;
      end else if (brownout_flag_r & brownout_irq_enable_r) begin
        irq_vector <= syc_pkg::VEC_BROWNOUT;
      end else begin
        irq_vector <= syc_pkg::VEC_WAKEUP;
      end
    end
  end

endmodule // syc_sys_ctrl
`default_nettype wire

// ### verif/syc_sys_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module syc_sys_ctrl_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pin settings
  input wire logic shared_pin_slew_enable,
  input wire logic shared_port_pin_slew,
  // detector and requests
  input wire logic deep_stop_allowed,
  input wire logic brownout_detector_on,
  input wire logic brownout_trip,
  input wire logic system_reset_req,
  input wire logic irq_brownout,
  input wire logic irq_wakeup,
  input wire logic irq_pending,
  input wire logic [4:0] irq_vector
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_setup_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  stop_block_a: assert property (!deep_stop_allowed && !$past(rst) && !$past(rst, 2) |->
    brownout_detector_on) else $error("deep stop blocked while detector off");
  vec_reset_a: assert property (system_reset_req [*2] |->
    irq_pending && irq_vector == syc_pkg::VEC_RESET) else $error("reset vector wrong");
  vec_brown_a: assert property ((irq_brownout && !system_reset_req) [*2] |->
    irq_vector == syc_pkg::VEC_BROWNOUT) else $error("brownout vector wrong");
  vec_wake_a: assert property ((irq_wakeup && !irq_brownout && !system_reset_req) [*2] |->
    irq_vector == syc_pkg::VEC_WAKEUP) else $error("wakeup vector wrong");
  pend_idle_a: assert property ((!irq_wakeup && !irq_brownout && !system_reset_req) [*2] |->
    !irq_pending) else $error("pending without source");
  reset_hold_a: assert property ($fell(system_reset_req) |-> !$past(brownout_trip, 2))
    else $error("reset request dropped while supply low");
  slew_pass_a: assert property (!$past(rst) |->
    shared_port_pin_slew == $past(shared_pin_slew_enable))
    else $error("slew setting not passed");
  brown_c: cover property ($rose(irq_brownout));
  wake_c: cover property ($rose(irq_wakeup));
  reset_c: cover property ($rose(system_reset_req));
  slverr_c: cover property (pslverr);
endmodule // syc_sys_ctrl_properties
`default_nettype wire

// ### verif/test_syc_sys_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_syc_sys_ctrl;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic por_in, brownout_trip, warning_trip, stop_active, deep_stop_request;
  logic lfo_clk_in, ext_clk_in, osc_stop_enable, osc_range_select;
  logic port_data, port_dir_out, shared_pin_slew_enable, shared_pin_drive_strength;
  logic brownout_detector_on, brownout_threshold_high, warning_threshold_high;
  logic deep_stop_allowed, system_reset_req, irq_brownout, irq_wakeup, irq_pending;
  logic [4:0] irq_vector;
  logic pin_out, pin_oe_n, pin_slew, pin_drive;
  int miscompares = 0;
  int checked = 0;
  syc_sys_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_in(por_in), .brownout_trip(brownout_trip),
    .warning_trip(warning_trip), .stop_active(stop_active),
    .deep_stop_request(deep_stop_request), .lfo_clk_in(lfo_clk_in), .ext_clk_in(ext_clk_in),
    .osc_stop_enable(osc_stop_enable), .osc_range_select(osc_range_select),
    .port_data(port_data), .port_dir_out(port_dir_out),
    .shared_pin_slew_enable(shared_pin_slew_enable),
    .shared_pin_drive_strength(shared_pin_drive_strength),
    .brownout_detector_on(brownout_detector_on),
    .brownout_threshold_high(brownout_threshold_high),
    .warning_threshold_high(warning_threshold_high), .deep_stop_allowed(deep_stop_allowed),
    .system_reset_req(system_reset_req), .irq_brownout(irq_brownout),
    .irq_wakeup(irq_wakeup), .irq_pending(irq_pending), .irq_vector(irq_vector),
    .shared_port_pin_out(pin_out), .shared_port_pin_oe_n(pin_oe_n),
    .shared_port_pin_slew(pin_slew), .shared_port_pin_drive(pin_drive));
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(pready, 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    check(rdv, e);
  endtask
  task automatic tick(input logic x, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (x) ext_clk_in <= 1'b1;
      else lfo_clk_in <= 1'b1;
      @(posedge ref_clk);
      ext_clk_in <= 1'b0;
      lfo_clk_in <= 1'b0;
    end
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(syc_pkg::OFS_PWR1, 32'h0000_0005);
    rd(syc_pkg::OFS_RSRC, 32'h0000_0082);
    check(brownout_detector_on, 1'b1);
    check(deep_stop_allowed, 1'b1);
    wr(8'h14, 32'h0000_00FF);
    check(rerr, 1'b1);
    rd(8'h14, 32'h0000_0000);
    check(rerr, 1'b1);
    wr(syc_pkg::OFS_RSRC, 32'h0000_0000);
    rd(syc_pkg::OFS_RSRC, 32'h0000_0082);
  endtask
  task automatic t_brown_irq();
    wr(syc_pkg::OFS_PWR1, 32'h0000_0009);
    brownout_trip <= 1'b1;
    cyc(3);
    check(irq_brownout, 1'b1);
    check(irq_pending, 1'b1);
    cyc(1);
    check(irq_vector, syc_pkg::VEC_BROWNOUT);
    rd(syc_pkg::OFS_PWR1, 32'h0000_0089);
    brownout_trip <= 1'b0;
    wr(syc_pkg::OFS_PWR1, 32'h0000_0019);
    cyc(2);
    check(irq_brownout, 1'b0);
    warning_trip <= 1'b1;
    cyc(3);
    rd(syc_pkg::OFS_PWR2, 32'h0000_0080);
    check(irq_pending, 1'b0);
    warning_trip <= 1'b0;
    wr(syc_pkg::OFS_PWR2, 32'h0000_0007);
    cyc(2);
    check(brownout_threshold_high, 1'b1);
    check(warning_threshold_high, 1'b1);
    rd(syc_pkg::OFS_PWR2, 32'h0000_0003);
  endtask
  task automatic t_stop();
    wr(syc_pkg::OFS_PWR1, 32'h0000_0001);
    stop_active <= 1'b1;
    cyc(3);
    check(brownout_detector_on, 1'b0);
    check(deep_stop_allowed, 1'b1);
    wr(syc_pkg::OFS_PWR1, 32'h0000_0003);
    cyc(2);
    check(brownout_detector_on, 1'b1);
    check(deep_stop_allowed, 1'b0);
    wr(syc_pkg::OFS_PWR1, 32'h0000_0000);
    stop_active <= 1'b0;
    brownout_trip <= 1'b1;
    cyc(3);
    check(brownout_detector_on, 1'b0);
    rd(syc_pkg::OFS_PWR1, 32'h0000_0000);
    brownout_trip <= 1'b0;
  endtask
  task automatic t_wake();
    for (int s = 1; s < 4; s++) begin
      wr(syc_pkg::OFS_WAKE, 32'h0000_0040 | 32'(s));
      tick(1'b0, (8 << (s - 1)) - 1);
      rd(syc_pkg::OFS_WAKE, 32'(s));
      tick(1'b0, 1);
      rd(syc_pkg::OFS_WAKE, 32'h0000_0080 | 32'(s));
    end
    wr(syc_pkg::OFS_WAKE, 32'h0000_0051);
    tick(1'b0, 8);
    check(irq_wakeup, 1'b1);
    check(irq_vector, syc_pkg::VEC_WAKEUP);
    wr(syc_pkg::OFS_WAKE, 32'h0000_0001);
    cyc(2);
    check(irq_wakeup, 1'b0);
    wr(syc_pkg::OFS_WAKE, 32'h0000_0010);
    tick(1'b0, 16);
    rd(syc_pkg::OFS_WAKE, 32'h0000_0090);
    check(irq_wakeup, 1'b0);
    wr(syc_pkg::OFS_WAKE, 32'h0000_0061);
    tick(1'b0, 8);
    tick(1'b1, 8);
    rd(syc_pkg::OFS_WAKE, 32'h0000_00A1);
    wr(syc_pkg::OFS_WAKE, 32'h0000_0061);
    stop_active <= 1'b1;
    deep_stop_request <= 1'b1;
    tick(1'b1, 8);
    rd(syc_pkg::OFS_WAKE, 32'h0000_0021);
    wr(syc_pkg::OFS_WAKE, 32'h0000_0041);
    tick(1'b0, 8);
    rd(syc_pkg::OFS_WAKE, 32'h0000_0081);
    wr(syc_pkg::OFS_WAKE, 32'h0000_0061);
    deep_stop_request <= 1'b0;
    osc_stop_enable <= 1'b1;
    tick(1'b1, 8);
    rd(syc_pkg::OFS_WAKE, 32'h0000_00A1);
    osc_range_select <= 1'b1;
    wr(syc_pkg::OFS_WAKE, 32'h0000_0061);
    tick(1'b1, 8);
    rd(syc_pkg::OFS_WAKE, 32'h0000_0021);
    osc_range_select <= 1'b0;
    stop_active <= 1'b0;
    wr(syc_pkg::OFS_WAKE, 32'h0000_0040);
  endtask
  task automatic toggles(input int e);
    int tg;
    logic prev;
    tg = 0;
    prev = pin_out;
    repeat (16) begin
      @(posedge ref_clk);
      if (pin_out !== prev) tg++;
      prev = pin_out;
    end
    check(32'(tg), 32'(e));
  endtask
  task automatic t_clkout();
    for (int s = 1; s < 4; s++) begin
      wr(syc_pkg::OFS_CLKO, 32'((s << 1) | 1));
      cyc(2);
      toggles(16 >> (s - 1));
      check(pin_oe_n, 1'b0);
    end
    wr(syc_pkg::OFS_CLKO, 32'h0000_0001);
    cyc(3);
    toggles(0);
    check(pin_out, 1'b0);
    wr(syc_pkg::OFS_CLKO, 32'h0000_0000);
    shared_pin_slew_enable <= 1'b1;
    shared_pin_drive_strength <= 1'b1;
    cyc(2);
    check(pin_oe_n, 1'b1);
    check(pin_drive, 1'b1);
    check(pin_slew, 1'b1);
    port_dir_out <= 1'b1;
    port_data <= 1'b1;
    cyc(2);
    check(pin_oe_n, 1'b0);
    check(pin_out, 1'b1);
  endtask
  task automatic t_brown_reset();
    wr(syc_pkg::OFS_PWR1, 32'h0000_0005);
    brownout_trip <= 1'b1;
    cyc(3);
    check(system_reset_req, 1'b1);
    cyc(1);
    check(irq_vector, syc_pkg::VEC_RESET);
    rd(syc_pkg::OFS_PWR1, 32'h0000_0005);
    check(system_reset_req, 1'b1);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    rd(syc_pkg::OFS_RSRC, 32'h0000_0002);
    brownout_trip <= 1'b0;
    cyc(3);
    check(system_reset_req, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {ref_clk, psel, penable, pwrite, paddr, pwdata, brownout_trip, warning_trip} = '0;
    {stop_active, deep_stop_request, lfo_clk_in, ext_clk_in, osc_stop_enable} = '0;
    {osc_range_select, port_data, port_dir_out} = '0;
    {shared_pin_slew_enable, shared_pin_drive_strength} = '0;
    rst = 1'b1;
    por_in = 1'b1;
    cyc(12);
    rst <= 1'b0;
    por_in <= 1'b0;
    t_reset();
    t_brown_irq();
    t_stop();
    t_wake();
    t_clkout();
    t_brown_reset();
    finish_test();
  end
  initial begin
    cyc(30000);
    miscompares++;
    finish_test();
  end
endmodule // test_syc_sys_ctrl
bind syc_sys_ctrl syc_sys_ctrl_properties i_props (.ref_clk(ref_clk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .shared_pin_slew_enable(shared_pin_slew_enable), .shared_port_pin_slew(shared_port_pin_slew),
  .deep_stop_allowed(deep_stop_allowed), .brownout_detector_on(brownout_detector_on),
  .brownout_trip(brownout_trip), .system_reset_req(system_reset_req),
  .irq_brownout(irq_brownout), .irq_wakeup(irq_wakeup), .irq_pending(irq_pending),
  .irq_vector(irq_vector));
`default_nettype wire
